// ### umc_pkg.sv
package umc_pkg;

   // ==========================================================
   // host register addresses
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_MSR = 3'h6;

   // ==========================================================
   // modem_control field positions
   localparam int MCR_DTR_BIT = 0;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_AUX1_BIT = 2;
   localparam int MCR_AUX2_BIT = 3;
   localparam int MCR_LOOP_BIT = 4;
   localparam logic [7:0] MCR_WRITE_MASK = 8'h1f;

   // ==========================================================
   // other control field positions
   localparam int LCR_DIVISOR_ACCESS_BIT_BIT = 7;
   localparam int IER_MSI_BIT = 3;

   // ==========================================================
   // modem status indices: 0 cts, 1 dsr, 2 ri, 3 dcd
   localparam int MS_CTS = 0;
   localparam int MS_DSR = 1;
   localparam int MS_RI = 2;
   localparam int MS_DCD = 3;

   // ==========================================================
   // reset values
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] DIV_BYTE_RESET = 8'h00;
   localparam logic [3:0] MS_PIN_RESET = 4'hf;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [15:0] BAUD_CNT_ONE = 16'h0001;

endpackage

// ### umc_baud_if.sv
`timescale 1ns/1ps
interface umc_baud_if;
   logic [15:0] divisor;
   logic reload;
   logic tick;

   modport gen (
      input divisor,
      input reload,
      output tick
   );

   modport ctl (
      output divisor,
      output reload,
      input tick
   );
endinterface

// ### umc_baud_gen.sv
`timescale 1ns/1ps
module umc_baud_gen
   import umc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   umc_baud_if.gen bif
);

   logic [15:0] cnt_q;
   logic tick_q;

   // ==========================================================
   // divider: one tick every divisor cycles, 16x the bit rate
   // a divisor of zero behaves as one, ticking every cycle
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= BAUD_CNT_ONE;
         tick_q <= 1'b0;
      end else if (bif.reload) begin
         cnt_q <= bif.divisor;
         tick_q <= 1'b0;
      end else if (cnt_q <= BAUD_CNT_ONE) begin
         cnt_q <= bif.divisor;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q - BAUD_CNT_ONE;
         tick_q <= 1'b0;
      end
   end

   assign bif.tick = tick_q;

   // ==========================================================
   // checks
   sequence s_tick_div3;
      tick_q && bif.divisor == 16'h0003 && !bif.reload
         ##1 (!bif.reload && bif.divisor == 16'h0003) [*2];
   endsequence

   a_reload_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      bif.reload |=> cnt_q == $past(bif.divisor) && !tick_q)
      else $error("baud counter not reloaded on divisor write");

   a_tick_period: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      s_tick_div3 |=> tick_q && $past(!tick_q, 1) && $past(!tick_q, 2))
      else $error("baud tick period differs from divisor");

endmodule

// ### umc_modem_top.sv
`timescale 1ns/1ps
// Overview of operation
// - dtr pin driven low while control bit 0 is one, high otherwise.
// - rts pin driven low while control bit 1 is one, high otherwise.
// - control bit 2 does nothing outside loopback.
// - control bit 3 enables the channel interrupt output; zero keeps it off.
// - loopback holds tx pin high, ignores rx pin, loops tx shifter to rx.
// - loopback disconnects modem input pins and forces dtr and rts high.
// - loopback status bits 4..7 show rts, dtr, aux one, aux two.
// - loopback modem status interrupts come only from the low four control bits.
// - control bits 5 to 7 always read zero.
// - delta bits set when cts, dsr or dcd change since last read.
// - ring edge bit sets only when the ri pin goes low to high.
// - outside loopback status bits 4..7 are inverted cts, dsr, ri, dcd.
// - enabled modem status interrupt raised while any delta bit set.
// - status read clears delta bits, leaves level bits alone.
// - events during a status read are applied at the read's end.
// - bit already set that recurs during read is cleared at read's end.
// - baud divider divides by the 16-bit divisor built from two bytes.
// - writing either divisor byte reloads the baud counter one cycle after the byte is stored.
// - baud output is a 16x bit rate sampling tick.
// - divisor bytes reachable only while line control bit 7 is one.
module umc_modem_top
   import umc_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic [2:0] HOST_ADDR_IN,
   input wire logic [7:0] HOST_WDATA_IN,
   input wire logic HOST_WR_STROBE_IN,
   input wire logic HOST_READ_STROBE_IN,
   input wire logic CTS_B_IN,
   input wire logic DSR_B_IN,
   input wire logic RI_B_IN,
   input wire logic DCD_B_IN,
   input wire logic SERIAL_RX_IN,
   input wire logic TX_SHIFT_REG_IN,
   input wire logic CHAN_IRQ_IN,
   output logic [7:0] HOST_RDATA_OUT,
   output logic [7:0] LINE_CTRL_OUT,
   output logic [7:0] INT_ENABLE_OUT,
   output logic DTR_B_OUT,
   output logic RTS_B_OUT,
   output logic SERIAL_TX_PIN_OUT,
   output logic RX_SHIFT_REG_OUT,
   output logic MODEM_INT_OUT,
   output logic SERIAL_INT_OUT,
   output logic BAUD_TICK_OUT
);

   // ==========================================================
   // declarations
   logic [7:0] modem_control_q;
   logic [7:0] line_control_reg_q;
   logic [7:0] interrupt_enable_reg_q;
   logic [7:0] divisor_low_byte_q;
   logic [7:0] divisor_high_byte_q;
   logic reload_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;
   logic [3:0] level_q;
   logic [3:0] level_d;
   logic [3:0] delta_q;
   logic [3:0] pend_q;
   logic [3:0] event_d;
   logic rd_msr_q;
   logic dtr_b_q;
   logic rts_b_q;
   logic tx_pin_q;
   logic rx_shift_q;
   logic modem_int_q;
   logic serial_int_q;
   logic divisor_access_bit;
   logic loop_on;
   logic wr_dll;
   logic wr_dlm;
   logic wr_ier;
   logic wr_lcr;
   logic wr_mcr;
   logic rd_msr;
   logic rd_end;
   logic msi_now;
   logic [3:0] loop_level;

   umc_baud_if baud_bus();

   // ==========================================================
   // host write decode
   assign divisor_access_bit = line_control_reg_q[LCR_DIVISOR_ACCESS_BIT_BIT];
   assign loop_on = modem_control_q[MCR_LOOP_BIT];

   always_comb begin
      wr_dll = 1'b0;
      wr_dlm = 1'b0;
      wr_ier = 1'b0;
      wr_lcr = 1'b0;
      wr_mcr = 1'b0;
      if (!HOST_WR_STROBE_IN) begin
         wr_dll = 1'b0;
      end else if (HOST_ADDR_IN == ADDR_DATA) begin
         wr_dll = divisor_access_bit;
      end else if (HOST_ADDR_IN == ADDR_IER) begin
         wr_dlm = divisor_access_bit;
         wr_ier = !divisor_access_bit;
      end else if (HOST_ADDR_IN == ADDR_LCR) begin
         wr_lcr = 1'b1;
      end else if (HOST_ADDR_IN == ADDR_MCR) begin
         wr_mcr = 1'b1;
      end
   end

   // ==========================================================
   // control registers
   // status register writes are dropped: nothing software may store there
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         modem_control_q <= MCR_RESET;
      end else if (wr_mcr) begin
         modem_control_q <= HOST_WDATA_IN & MCR_WRITE_MASK;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         line_control_reg_q <= LCR_RESET;
      end else if (wr_lcr) begin
         line_control_reg_q <= HOST_WDATA_IN;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         interrupt_enable_reg_q <= IER_RESET;
      end else if (wr_ier) begin
         interrupt_enable_reg_q <= HOST_WDATA_IN;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         divisor_low_byte_q <= DIV_BYTE_RESET;
         divisor_high_byte_q <= DIV_BYTE_RESET;
      end else begin
         if (wr_dll) begin
            divisor_low_byte_q <= HOST_WDATA_IN;
         end
         if (wr_dlm) begin
            divisor_high_byte_q <= HOST_WDATA_IN;
         end
      end
   end

   // reload lags the byte write so the counter sees the new divisor
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         reload_q <= 1'b0;
      end else begin
         reload_q <= wr_dll | wr_dlm;
      end
   end

   // ==========================================================
   // baud generator
   assign baud_bus.divisor = {divisor_high_byte_q, divisor_low_byte_q};
   assign baud_bus.reload = reload_q;

   umc_baud_gen u_baud_generator (
      .clk_in(SYS_CLK_IN),
      .rst_b_in(RST_B_IN),
      .bif(baud_bus.gen)
   );

   // ==========================================================
   // modem input synchroniser, pins are active low
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pin_meta_q <= MS_PIN_RESET;
         pin_sync_q <= MS_PIN_RESET;
      end else begin
         pin_meta_q <= {DCD_B_IN, RI_B_IN, DSR_B_IN, CTS_B_IN};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ==========================================================
   // status levels and change events
   // in loopback the pins are ignored; control bits stand in for them
   assign loop_level = {modem_control_q[MCR_AUX2_BIT],
                        modem_control_q[MCR_AUX1_BIT],
                        modem_control_q[MCR_DTR_BIT],
                        modem_control_q[MCR_RTS_BIT]};

   always_comb begin
      if (loop_on) begin
         level_d = loop_level;
      end else begin
         level_d = ~pin_sync_q;
      end
      event_d[MS_CTS] = level_d[MS_CTS] ^ level_q[MS_CTS];
      event_d[MS_DSR] = level_d[MS_DSR] ^ level_q[MS_DSR];
      event_d[MS_RI] = level_q[MS_RI] & ~level_d[MS_RI];
      event_d[MS_DCD] = level_d[MS_DCD] ^ level_q[MS_DCD];
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         level_q <= ~MS_PIN_RESET;
      end else begin
         level_q <= level_d;
      end
   end

   // ==========================================================
   // status read sequencing
   assign rd_msr = HOST_READ_STROBE_IN && (HOST_ADDR_IN == ADDR_MSR);
   assign rd_end = rd_msr_q && !rd_msr;

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rd_msr_q <= 1'b0;
      end else begin
         rd_msr_q <= rd_msr;
      end
   end

   // events seen while the strobe is high wait for its trailing edge
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pend_q <= 4'h0;
      end else if (rd_msr) begin
         pend_q <= pend_q | event_d;
      end else begin
         pend_q <= 4'h0;
      end
   end

   // a recurring event on an already set bit toggles it clear here,
   // so the clear deliberately wins at the end of a read
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         delta_q <= 4'h0;
      end else if (rd_end) begin
         delta_q <= (pend_q | event_d) & ~delta_q;
      end else if (!rd_msr) begin
         delta_q <= delta_q | event_d;
      end
   end

   // ==========================================================
   // read data
   always_comb begin
      rdata_d = UNMAPPED_READ;
      if (HOST_ADDR_IN == ADDR_DATA) begin
         if (divisor_access_bit) begin
            rdata_d = divisor_low_byte_q;
         end
      end else if (HOST_ADDR_IN == ADDR_IER) begin
         if (divisor_access_bit) begin
            rdata_d = divisor_high_byte_q;
         end else begin
            rdata_d = interrupt_enable_reg_q;
         end
      end else if (HOST_ADDR_IN == ADDR_LCR) begin
         rdata_d = line_control_reg_q;
      end else if (HOST_ADDR_IN == ADDR_MCR) begin
         rdata_d = modem_control_q;
      end else if (HOST_ADDR_IN == ADDR_MSR) begin
         rdata_d = {level_q, delta_q};
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rdata_q <= UNMAPPED_READ;
      end else if (HOST_READ_STROBE_IN) begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // modem and serial pins
   // aux one has no pin; it only feeds the loopback ring level
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dtr_b_q <= 1'b1;
         rts_b_q <= 1'b1;
      end else begin
         dtr_b_q <= !(modem_control_q[MCR_DTR_BIT] && !loop_on);
         rts_b_q <= !(modem_control_q[MCR_RTS_BIT] && !loop_on);
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tx_pin_q <= 1'b1;
         rx_shift_q <= 1'b1;
      end else if (loop_on) begin
         tx_pin_q <= 1'b1;
         rx_shift_q <= TX_SHIFT_REG_IN;
      end else begin
         tx_pin_q <= TX_SHIFT_REG_IN;
         rx_shift_q <= SERIAL_RX_IN;
      end
   end

   // ==========================================================
   // interrupts
   assign msi_now = interrupt_enable_reg_q[IER_MSI_BIT] && (|delta_q);

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         modem_int_q <= 1'b0;
         serial_int_q <= 1'b0;
      end else begin
         modem_int_q <= msi_now;
         serial_int_q <= modem_control_q[MCR_AUX2_BIT]
                         && (msi_now || CHAN_IRQ_IN);
      end
   end

   // ==========================================================
   // outputs
   assign HOST_RDATA_OUT = rdata_q;
   assign LINE_CTRL_OUT = line_control_reg_q;
   assign INT_ENABLE_OUT = interrupt_enable_reg_q;
   assign DTR_B_OUT = dtr_b_q;
   assign RTS_B_OUT = rts_b_q;
   assign SERIAL_TX_PIN_OUT = tx_pin_q;
   assign RX_SHIFT_REG_OUT = rx_shift_q;
   assign MODEM_INT_OUT = modem_int_q;
   assign SERIAL_INT_OUT = serial_int_q;
   assign BAUD_TICK_OUT = baud_bus.tick;

   // ==========================================================
   // checks
   sequence s_msr_read_quiet;
      rd_msr && event_d == 4'h0 && pend_q == 4'h0 ##1 rd_end && event_d == 4'h0;
   endsequence

   sequence s_mcr_dtr_on;
      wr_mcr && HOST_WDATA_IN[MCR_DTR_BIT] && !HOST_WDATA_IN[MCR_LOOP_BIT];
   endsequence

   a_dtr_asserted: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      s_mcr_dtr_on |-> ##2 !DTR_B_OUT)
      else $error("dtr pin not low after control bit 0 set");

   a_rts_level: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      wr_mcr && !HOST_WDATA_IN[MCR_RTS_BIT] |-> ##2 RTS_B_OUT)
      else $error("rts pin not high after control bit 1 cleared");

   a_loop_pins_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      loop_on |=> DTR_B_OUT && RTS_B_OUT && SERIAL_TX_PIN_OUT)
      else $error("loopback did not idle the output pins");

   a_loop_rx_path: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      loop_on |=> RX_SHIFT_REG_OUT == $past(TX_SHIFT_REG_IN))
      else $error("loopback did not feed tx shifter into rx");

   a_int_gate_off: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      !modem_control_q[MCR_AUX2_BIT] |=> !SERIAL_INT_OUT)
      else $error("channel interrupt active while disabled");

   a_msi_raise: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      interrupt_enable_reg_q[IER_MSI_BIT] && delta_q != 4'h0
      |=> MODEM_INT_OUT)
      else $error("modem status interrupt missing");

   a_mcr_high_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      HOST_READ_STROBE_IN && HOST_ADDR_IN == ADDR_MCR
      |=> HOST_RDATA_OUT[7:5] == 3'h0)
      else $error("control bits 5 to 7 read nonzero");

   a_msr_read_clear: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      s_msr_read_quiet |=> delta_q == 4'h0)
      else $error("delta bits not cleared by status read");

   a_read_holdoff: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      rd_msr && !rd_end |=> delta_q == $past(delta_q))
      else $error("status bit changed during a status read");

   a_ring_trailing_edge_no_fall: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      !rd_msr && !rd_end && !delta_q[MS_RI] && level_d[MS_RI] == level_q[MS_RI]
      |=> !delta_q[MS_RI])
      else $error("ring edge bit set without a rising ri");

   a_loop_status: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      loop_on && $stable(modem_control_q) && rd_msr
      |=> HOST_RDATA_OUT[7:4] == $past(loop_level))
      else $error("loopback status does not mirror control bits");

   a_divisor_access_bit_guard: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      HOST_WR_STROBE_IN && HOST_ADDR_IN == ADDR_DATA && !divisor_access_bit
      |=> $stable(divisor_low_byte_q))
      else $error("divisor byte written with access bit clear");

endmodule

// ### umc_modem_peer.sv
`timescale 1ns/1ps
module umc_modem_peer (
   input wire logic clk_in,
   input wire logic [3:0] want_b_in,
   input wire logic dtr_b_in,
   input wire logic rts_b_in,
   output logic [3:0] pins_b_out
);
   // ==========================================================
   // modem handshake pins, idle high; index order cts, dsr, ri, dcd
   // levels move just after a falling edge, one cycle behind the
   // request, so the device never sees a change on its own edge
   initial pins_b_out = 4'hf;
   always @(negedge clk_in) begin
      pins_b_out <= want_b_in;
   end
endmodule

// ### uart_modem_ctrl_status_baudgen_bench.sv
`timescale 1ns/1ps
module uart_modem_ctrl_status_baudgen_bench;
   import umc_pkg::*;
   logic clk, rst_b, wr, rd, rx, txs, irq;
   logic [2:0] addr;
   logic [7:0] wd, rdata, v;
   logic [7:0] lcr_o, ier_o;
   logic [3:0] want_b, pins_b, lvl, dl;
   logic dtr_b, rts_b, txp, rxs, mint, sint, tick;
   int err_count = 0;
   int checked = 0;
   int n;

   umc_modem_top umc_modem_top_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
      .HOST_ADDR_IN(addr), .HOST_WDATA_IN(wd), .HOST_WR_STROBE_IN(wr),
      .HOST_READ_STROBE_IN(rd), .CTS_B_IN(pins_b[0]),
      .DSR_B_IN(pins_b[1]), .RI_B_IN(pins_b[2]), .DCD_B_IN(pins_b[3]),
      .SERIAL_RX_IN(rx), .TX_SHIFT_REG_IN(txs), .CHAN_IRQ_IN(irq),
      .HOST_RDATA_OUT(rdata), .LINE_CTRL_OUT(lcr_o), .INT_ENABLE_OUT(ier_o),
      .DTR_B_OUT(dtr_b), .RTS_B_OUT(rts_b), .SERIAL_TX_PIN_OUT(txp),
      .RX_SHIFT_REG_OUT(rxs), .MODEM_INT_OUT(mint),
      .SERIAL_INT_OUT(sint), .BAUD_TICK_OUT(tick));

   umc_modem_peer umc_modem_peer_i (.clk_in(clk), .want_b_in(want_b),
      .dtr_b_in(dtr_b), .rts_b_in(rts_b), .pins_b_out(pins_b));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // report, check, host access and baud tick wait tasks
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // two extra idle cycles let the register reach the pins before checks
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // len cycles of strobe; the strobe's fall is the trailing edge
   task automatic rd_reg(input logic [2:0] a, input int len,
                         output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      repeat (len) @(negedge clk);
      rd = 1'b0;
      repeat (2) @(negedge clk);
      d = rdata;
   endtask

   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (tick !== 1'b1 && c < 1000);
      if (c >= 1000) begin
         err_count++;
         $display("ERROR %0t baud tick missing", $time);
         complete_run();
      end
   endtask

   // ==========================================================
   // test sequence
   initial begin
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      rx = 1'b1;
      txs = 1'b1;
      irq = 1'b0;
      addr = 3'h0;
      wd = 8'h00;
      want_b = 4'hf;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      check({4'h0, dtr_b, rts_b, mint, sint}, 8'h0c);
      rd_reg(ADDR_MCR, 1, v);
      check(v, MCR_RESET);
      $display("reset test done");

      wr_reg(ADDR_MCR, 8'h03);
      check({6'h00, dtr_b, rts_b}, 8'h00);
      wr_reg(ADDR_MCR, 8'h01);
      check({6'h00, dtr_b, rts_b}, 8'h01);
      txs = 1'b0;
      irq = 1'b1;
      wr_reg(ADDR_MCR, 8'he4);
      check({4'h0, dtr_b, rts_b, txp, rxs}, 8'h0d);
      check({7'h00, sint}, 8'h00);
      rd_reg(ADDR_MCR, 1, v);
      check(v, 8'h04);
      wr_reg(ADDR_MCR, 8'h08);
      check({7'h00, sint}, 8'h01);
      irq = 1'b0;
      wr_reg(ADDR_IER, 8'h08);
      check(ier_o, 8'h08);
      $display("control test done");

      lvl = 4'h0;
      for (int i = 0; i < 4; i++) begin
         want_b[i] = 1'b0;
         repeat (8) @(negedge clk);
         lvl[i] = 1'b1;
         dl = 4'h0;
         dl[i] = (i != MS_RI);
         check({6'h00, mint, sint}, {6'h00, |dl, |dl});
         rd_reg(ADDR_MSR, 1, v);
         check(v, {lvl, dl});
         rd_reg(ADDR_MSR, 1, v);
         check(v, {lvl, 4'h0});
         check({7'h00, mint}, 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         want_b[i] = 1'b1;
         repeat (8) @(negedge clk);
         lvl[i] = 1'b0;
         dl = 4'h0;
         dl[i] = 1'b1;
         rd_reg(ADDR_MSR, 1, v);
         check(v, {lvl, dl});
         rd_reg(ADDR_MSR, 1, v);
         check(v, {lvl, 4'h0});
      end
      $display("status test done");
      // the host only reads the status register, never writes it

      fork
         rd_reg(ADDR_MSR, 8, v);
         begin
            repeat (2) @(negedge clk);
            want_b[MS_DSR] = 1'b0;
         end
      join
      check(v, 8'h20);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'h22);
      want_b[MS_DSR] = 1'b1;
      repeat (8) @(negedge clk);
      fork
         rd_reg(ADDR_MSR, 8, v);
         begin
            repeat (2) @(negedge clk);
            want_b[MS_DSR] = 1'b0;
         end
      join
      check(v, 8'h22);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'h20);
      want_b[MS_DSR] = 1'b1;
      repeat (8) @(negedge clk);
      rd_reg(ADDR_MSR, 1, v);
      $display("read hold-off test done");

      // entering loopback may itself flag changes, so flush them first
      wr_reg(ADDR_MCR, 8'h10);
      rd_reg(ADDR_MSR, 1, v);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'h00);
      wr_reg(ADDR_MCR, 8'h13);
      repeat (4) @(negedge clk);
      check({5'h00, dtr_b, rts_b, mint}, 8'h07);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'h33);
      txs = 1'b0;
      rx = 1'b1;
      repeat (3) @(negedge clk);
      check({6'h00, txp, rxs}, 8'h02);
      txs = 1'b1;
      rx = 1'b0;
      repeat (3) @(negedge clk);
      check({6'h00, txp, rxs}, 8'h03);
      want_b = 4'h0;
      repeat (8) @(negedge clk);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'h30);
      wr_reg(ADDR_MCR, 8'h1c);
      rd_reg(ADDR_MSR, 1, v);
      check(v, 8'hcb);
      want_b = 4'hf;
      rx = 1'b1;
      wr_reg(ADDR_MCR, 8'h00);
      repeat (8) @(negedge clk);
      rd_reg(ADDR_MSR, 1, v);
      $display("loopback test done");

      wr_reg(ADDR_LCR, 8'h80);
      check(lcr_o, 8'h80);
      wr_reg(ADDR_DATA, 8'h03);
      wr_reg(ADDR_IER, 8'h00);
      wait_tick(n);
      wait_tick(n);
      check(8'(n), 8'h03);
      wr_reg(ADDR_DATA, 8'h02);
      wr_reg(ADDR_IER, 8'h01);
      wait_tick(n);
      wait_tick(n);
      check(8'(n - 256), 8'h02);
      wr_reg(ADDR_IER, 8'h00);
      wait_tick(n);
      check({7'h00, n <= 3}, 8'h01);
      rd_reg(ADDR_DATA, 1, v);
      check(v, 8'h02);
      wr_reg(ADDR_LCR, 8'h00);
      rd_reg(ADDR_IER, 1, v);
      check(v, 8'h08);
      rd_reg(ADDR_DATA, 1, v);
      check(v, 8'h00);
      check(lcr_o, 8'h00);
      check(ier_o, 8'h08);
      $display("baud test done");
      complete_run();
   end
endmodule
